//--- qsfm_master.sv
// Quad serial flash master: command, fetch-window and DMA sequencer.
//
// Behaviour
// [RL1] Always master: drives clock and select, no slave mode.
// [RL2] Serial clock programmable between 2 MHz and 32 MHz; the divider clamp tops out at 25 MHz (half period of 2 ref cycles).
// [RL3] One active-low select held low for each whole transaction.
// [RL4] Single lane: line 0 carries data out, line 1 data in.
// [RL5] Dual and quad make lines bidirectional; lines 2-3 data only in quad.
// [RL6] Reads and writes on one, two or four lanes per operation.
// [RL7] Addresses sent to the flash are 32 bits wide.
// [RL8] Fetches into a 128 MB window at a base offset become reads.
// [RL9] Custom opcode plus up to eight data bytes, response read back.
// [RL10] Built-in deep power-down enter and exit commands.
// [RL11] Data words move to and from RAM without the processor.
// [RL12] Flash drives lines only in read response, releases when deselected.
`timescale 1ns/1ps
module qsfm_master #(
   parameter int DUMMY_CYC = qsfm_pkg::DUMMY_CYC_DEF
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [4:0] i_half,
   input wire logic i_cmd_valid,
   output logic o_cmd_ready,
   input wire logic [2:0] i_cmd_kind,
   input wire logic [1:0] i_cmd_lanes,
   input wire logic [31:0] i_cmd_addr,
   input wire logic [15:0] i_cmd_words,
   input wire logic [31:0] i_cmd_ram_addr,
   input wire logic [7:0] i_cust_opcode,
   input wire logic [63:0] i_cust_data,
   input wire logic [3:0] i_cust_tx_len,
   input wire logic [3:0] i_cust_rx_len,
   input wire logic i_xip_valid,
   output logic o_xip_ready,
   input wire logic [31:0] i_xip_base,
   input wire logic [26:0] i_xip_ofs,
   input wire logic [1:0] i_xip_lanes,
   output logic o_xip_rvalid,
   output logic [31:0] o_xip_rdata,
   output logic [31:0] o_ram_addr,
   output logic o_ram_rd_req,
   input wire logic i_ram_rd_ack,
   input wire logic [31:0] i_ram_rdata,
   output logic o_ram_wr_req,
   output logic [31:0] o_ram_wdata,
   input wire logic i_ram_wr_ack,
   output logic [63:0] o_cust_rsp,
   output logic o_busy,
   output logic o_done,
   output logic o_sck,
   output logic o_cs_n,
   output logic [3:0] o_io_out,
   output logic [3:0] o_io_oe,
   input wire logic [3:0] i_io_in
);
   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------
   function automatic logic [5:0] cyc32(input logic [1:0] ln);
      case (ln)
         qsfm_pkg::LANE_4: cyc32 = 6'd8;
         qsfm_pkg::LANE_2: cyc32 = 6'd16;
         default: cyc32 = 6'd32;
      endcase
   endfunction

   function automatic logic [31:0] bswap(input logic [31:0] w);
      bswap = {w[7:0], w[15:8], w[23:16], w[31:24]};
   endfunction

   function automatic logic [31:0] shin(input logic [31:0] r,
                                        input logic [3:0] d,
                                        input logic [1:0] ln);
      case (ln)
         qsfm_pkg::LANE_4: shin = {r[27:0], d};
         qsfm_pkg::LANE_2: shin = {r[29:0], d[1:0]};
         default: shin = {r[30:0], d[1]}; // [RL4]
      endcase
   endfunction

   function automatic logic [7:0] opc_of(input logic [2:0] k,
                                         input logic [1:0] ln);
      case (k)
         qsfm_pkg::CMD_WRITE: opc_of = (ln == qsfm_pkg::LANE_4) ?
            qsfm_pkg::OPC_PROG4 : (ln == qsfm_pkg::LANE_2) ?
            qsfm_pkg::OPC_PROG2 : qsfm_pkg::OPC_PROG1;
         qsfm_pkg::CMD_DPD_ENTER: opc_of = qsfm_pkg::OPC_DPD_IN; // [RL10]
         qsfm_pkg::CMD_DPD_EXIT: opc_of = qsfm_pkg::OPC_DPD_OUT; // [RL10]
         default: opc_of = (ln == qsfm_pkg::LANE_4) ?
            qsfm_pkg::OPC_READ4 : (ln == qsfm_pkg::LANE_2) ?
            qsfm_pkg::OPC_READ2 : qsfm_pkg::OPC_READ1;
      endcase
   endfunction

   // -------------------------------------------------------------------
   // State and decode
   // -------------------------------------------------------------------
   qsfm_pkg::qsfm_state_t state;
   logic [31:0] sh;
   logic [31:0] rx;
   logic [31:0] addr;
   logic [5:0] bcnt;
   logic [15:0] ucnt;
   logic [1:0] lanes;
   logic [2:0] kind;
   logic xip;
   logic [2:0] cidx;
   logic [3:0] txlen;
   logic [3:0] rxlen;
   logic [3:0] gcnt;
   logic [3:0] sync1;
   logic [3:0] sync2;
   logic rise;
   logic fall;
   logic run;
   logic last;
   logic multi;
   logic drive;
   logic cap;
   logic [1:0] cur_ln;
   logic [31:0] rx_next;
   logic [31:0] sh_next;
   logic [3:0] next_io_out;
   logic [3:0] next_io_oe;
   logic next_cs_n;

   assign run = (state == qsfm_pkg::ST_OPC) || (state == qsfm_pkg::ST_ADDR) ||
                (state == qsfm_pkg::ST_DUMMY) || (state == qsfm_pkg::ST_TX) ||
                (state == qsfm_pkg::ST_RX) || (state == qsfm_pkg::ST_CTX) ||
                (state == qsfm_pkg::ST_CRX);
   assign multi = (state == qsfm_pkg::ST_TX) || (state == qsfm_pkg::ST_FETCH) ||
                  (state == qsfm_pkg::ST_RX) || (state == qsfm_pkg::ST_STORE) ||
                  (state == qsfm_pkg::ST_DUMMY);
   assign drive = (state == qsfm_pkg::ST_OPC) || (state == qsfm_pkg::ST_ADDR) ||
                  (state == qsfm_pkg::ST_CTX) || (state == qsfm_pkg::ST_TX) ||
                  (state == qsfm_pkg::ST_FETCH);
   assign cap = (state == qsfm_pkg::ST_RX) || (state == qsfm_pkg::ST_CRX);
   assign cur_ln = multi ? lanes : qsfm_pkg::LANE_1; // [RL6]
   assign last = fall && (bcnt == 6'd1);
   assign rx_next = shin(rx, sync2, cur_ln);
   assign sh_next = (cur_ln == qsfm_pkg::LANE_4) ? {sh[27:0], 4'h0} :
                    (cur_ln == qsfm_pkg::LANE_2) ? {sh[29:0], 2'h0} :
                    {sh[30:0], 1'b0};
   assign o_busy = (state != qsfm_pkg::ST_IDLE);
   assign o_xip_ready = (state == qsfm_pkg::ST_IDLE);
   // Fetches take priority; a command waits while one is pending.
   assign o_cmd_ready = (state == qsfm_pkg::ST_IDLE) && !i_xip_valid;
   assign o_ram_rd_req = (state == qsfm_pkg::ST_FETCH); // [RL11]
   assign o_ram_wr_req = (state == qsfm_pkg::ST_STORE); // [RL11]

   // Lane drive. Lines 2-3 are held high as inactive controls outside
   // quad; in quad reads every line is released to the flash.
   assign next_cs_n = !(run || (state == qsfm_pkg::ST_FETCH) ||
                        (state == qsfm_pkg::ST_STORE)); // [RL3]
   assign next_io_out = (cur_ln == qsfm_pkg::LANE_4) ? sh[31:28] :
                        (cur_ln == qsfm_pkg::LANE_2) ? {2'b11, sh[31:30]} :
                        {3'b110, sh[31]}; // [RL4]
   assign next_io_oe = next_cs_n ? 4'h0 :
      {{2{(cur_ln != qsfm_pkg::LANE_4) || drive}},
       drive && (cur_ln != qsfm_pkg::LANE_1),
       drive || (cur_ln == qsfm_pkg::LANE_1)}; // [RL5]

   qsfm_sck_gen #(
      .HW(5)
   ) u_sck (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_run(run),
      .i_half(i_half),
      .o_sck(o_sck),
      .o_rise(rise),
      .o_fall(fall)
   ); // [RL1]

   // Pin registers and input synchroniser; outputs change one ref cycle after the sck fall.
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         o_cs_n <= 1'b1;
         o_io_out <= 4'h0;
         o_io_oe <= 4'h0;
         sync1 <= 4'h0;
         sync2 <= 4'h0;
      end else begin
         o_cs_n <= next_cs_n;
         o_io_out <= next_io_out;
         o_io_oe <= next_io_oe;
         sync1 <= i_io_in;
         sync2 <= sync1;
      end
   end

   // -------------------------------------------------------------------
   // Sequencer. Each phase ends on the sck fall after its last cycle.
   // Read data are sampled on the fall through the synchroniser, so
   // the sample reflects the pin two ref cycles before the fall, at the preceding rise at the fastest rate; this limits
   // the clock to what the flash output delay allows at that rate.
   // -------------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) begin
         state <= qsfm_pkg::ST_IDLE;
         sh <= '0;
         rx <= '0;
         addr <= '0;
         bcnt <= '0;
         ucnt <= '0;
         lanes <= qsfm_pkg::LANE_1;
         kind <= qsfm_pkg::CMD_READ;
         xip <= 1'b0;
         cidx <= '0;
         txlen <= '0;
         rxlen <= '0;
         gcnt <= '0;
         o_ram_addr <= '0;
         o_ram_wdata <= '0;
         o_xip_rdata <= '0;
         o_xip_rvalid <= 1'b0;
         o_cust_rsp <= '0;
         o_done <= 1'b0;
      end else begin
         o_xip_rvalid <= 1'b0;
         o_done <= 1'b0;
         if (fall && cap) rx <= rx_next;
         if (fall && drive) sh <= sh_next;
         if (fall && run) bcnt <= bcnt - 1'b1;
         case (state)
            qsfm_pkg::ST_IDLE: begin
               bcnt <= 6'(qsfm_pkg::OPC_BITS);
               if (i_xip_valid) begin
                  xip <= 1'b1;
                  kind <= qsfm_pkg::CMD_READ;
                  lanes <= i_xip_lanes;
                  ucnt <= 16'h0001;
                  addr <= i_xip_base + {5'h00, i_xip_ofs}; // [RL8]
                  sh <= {opc_of(qsfm_pkg::CMD_READ, i_xip_lanes), 24'h0};
                  state <= qsfm_pkg::ST_OPC;
               end else if (i_cmd_valid) begin
                  xip <= 1'b0;
                  kind <= i_cmd_kind;
                  lanes <= i_cmd_lanes;
                  ucnt <= i_cmd_words;
                  addr <= i_cmd_addr;
                  o_ram_addr <= i_cmd_ram_addr;
                  cidx <= '0;
                  txlen <= (i_cust_tx_len > 4'd8) ? 4'd8 : i_cust_tx_len;
                  rxlen <= (i_cust_rx_len > 4'd8) ? 4'd8 : i_cust_rx_len;
                  if (i_cmd_kind == qsfm_pkg::CMD_CUSTOM) begin
                     o_cust_rsp <= '0;
                     sh <= {i_cust_opcode, 24'h0}; // [RL9]
                  end else begin
                     sh <= {opc_of(i_cmd_kind, i_cmd_lanes), 24'h0};
                  end
                  state <= qsfm_pkg::ST_OPC;
               end
            end
            qsfm_pkg::ST_OPC: if (last) begin
               if (kind == qsfm_pkg::CMD_CUSTOM) begin
                  bcnt <= 6'd8;
                  sh <= {i_cust_data[7:0], 24'h0};
                  state <= (txlen != 4'd0) ? qsfm_pkg::ST_CTX :
                           (rxlen != 4'd0) ? qsfm_pkg::ST_CRX :
                           qsfm_pkg::ST_GAP; // [RL9]
               end else if (kind == qsfm_pkg::CMD_READ ||
                            kind == qsfm_pkg::CMD_WRITE) begin
                  bcnt <= 6'(qsfm_pkg::ADDR_BITS);
                  sh <= addr; // [RL7]
                  state <= qsfm_pkg::ST_ADDR;
               end else begin
                  state <= qsfm_pkg::ST_GAP; // [RL10]
               end
            end
            qsfm_pkg::ST_ADDR: if (last) begin
               bcnt <= (DUMMY_CYC > 0) ? 6'(DUMMY_CYC) : cyc32(lanes);
               if (ucnt == 16'h0000) state <= qsfm_pkg::ST_GAP;
               else if (kind == qsfm_pkg::CMD_WRITE)
                  state <= qsfm_pkg::ST_FETCH;
               else if (DUMMY_CYC > 0) state <= qsfm_pkg::ST_DUMMY;
               else state <= qsfm_pkg::ST_RX;
            end
            qsfm_pkg::ST_DUMMY: if (last) begin
               bcnt <= cyc32(lanes);
               state <= qsfm_pkg::ST_RX; // [RL12]
            end
            qsfm_pkg::ST_FETCH: if (i_ram_rd_ack) begin
               sh <= bswap(i_ram_rdata); // [RL11]
               bcnt <= cyc32(lanes);
               o_ram_addr <= o_ram_addr + 32'h0000_0004;
               state <= qsfm_pkg::ST_TX;
            end
            qsfm_pkg::ST_TX: if (last) begin
               ucnt <= ucnt - 1'b1;
               state <= (ucnt == 16'h0001) ? qsfm_pkg::ST_GAP :
                        qsfm_pkg::ST_FETCH;
            end
            qsfm_pkg::ST_RX: if (last) begin
               if (xip) begin
                  o_xip_rdata <= bswap(rx_next); // [RL8]
                  o_xip_rvalid <= 1'b1;
                  state <= qsfm_pkg::ST_GAP;
               end else begin
                  o_ram_wdata <= bswap(rx_next);
                  state <= qsfm_pkg::ST_STORE;
               end
            end
            qsfm_pkg::ST_STORE: if (i_ram_wr_ack) begin
               o_ram_addr <= o_ram_addr + 32'h0000_0004; // [RL11]
               ucnt <= ucnt - 1'b1;
               bcnt <= cyc32(lanes);
               state <= (ucnt == 16'h0001) ? qsfm_pkg::ST_GAP :
                        qsfm_pkg::ST_RX;
            end
            qsfm_pkg::ST_CTX: if (last) begin
               bcnt <= 6'd8;
               if ({1'b0, cidx} == txlen - 1'b1) begin
                  cidx <= '0;
                  state <= (rxlen != 4'd0) ? qsfm_pkg::ST_CRX :
                           qsfm_pkg::ST_GAP;
               end else begin
                  cidx <= cidx + 1'b1;
                  sh <= {i_cust_data[8 * (cidx + 3'd1) +: 8], 24'h0};
               end
            end
            qsfm_pkg::ST_CRX: if (last) begin
               bcnt <= 6'd8;
               o_cust_rsp[8 * cidx +: 8] <= rx_next[7:0]; // [RL9]
               cidx <= cidx + 1'b1;
               if ({1'b0, cidx} == rxlen - 1'b1) state <= qsfm_pkg::ST_GAP;
            end
            qsfm_pkg::ST_GAP: begin
               if (gcnt == 4'(qsfm_pkg::CS_HIGH_CYC)) begin
                  gcnt <= '0;
                  o_done <= 1'b1;
                  state <= qsfm_pkg::ST_IDLE;
               end else begin
                  gcnt <= gcnt + 1'b1;
               end
            end
            default: state <= qsfm_pkg::ST_IDLE;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   a_clock_in_frame: assert property ($changed(o_sck) |-> !o_cs_n) // [RL1]
      else $error("serial clock moved while deselected");
   a_select_frame: assert property (
      (state == qsfm_pkg::ST_GAP) |=> o_cs_n ##1 o_cs_n) // [RL3]
      else $error("select not high in gap");
   a_single_lines: assert property (
      (state == qsfm_pkg::ST_ADDR) |=> (o_io_oe[1:0] == 2'b01)) // [RL4]
      else $error("address not on line zero only");
   a_quad_release: assert property (
      (state == qsfm_pkg::ST_RX && lanes == qsfm_pkg::LANE_4)
      |=> (o_io_oe == 4'h0)) // [RL5]
      else $error("quad read lines still driven");
   a_lane_count: assert property (
      $rose(state == qsfm_pkg::ST_RX) |-> (bcnt == cyc32(lanes))) // [RL6]
      else $error("data cycle count wrong for lane width");
   a_addr_width: assert property (
      $rose(state == qsfm_pkg::ST_ADDR) |-> (bcnt == 6'd32 && sh == addr))
      else $error("address phase not 32 bits"); // [RL7]
   a_xip_addr: assert property (
      (state == qsfm_pkg::ST_IDLE && i_xip_valid) |=> xip &&
      (addr == $past(i_xip_base) + {5'h00, $past(i_xip_ofs)})) // [RL8]
      else $error("fetch address not base plus offset");
   a_cust_short: assert property (
      (state == qsfm_pkg::ST_OPC && last && kind == qsfm_pkg::CMD_CUSTOM &&
       txlen == 4'd0 && rxlen == 4'd0) |=> (state == qsfm_pkg::ST_GAP))
      else $error("bare custom opcode did not end"); // [RL9]
   a_dpd_short: assert property (
      (state == qsfm_pkg::ST_OPC && last &&
       kind == qsfm_pkg::CMD_DPD_ENTER) |=> (state == qsfm_pkg::ST_GAP))
      else $error("power-down command not opcode only"); // [RL10]
   a_dma_hold: assert property (
      (state == qsfm_pkg::ST_STORE && !i_ram_wr_ack) |=>
      (state == qsfm_pkg::ST_STORE) && $stable(o_ram_wdata)) // [RL11]
      else $error("RAM write word dropped under stall");

   c_xip_read: cover property (o_xip_rvalid);
   c_quad_write: cover property (state == qsfm_pkg::ST_TX &&
                                 lanes == qsfm_pkg::LANE_4 && last);
   c_cust_rsp: cover property (state == qsfm_pkg::ST_CRX && last);
endmodule // qsfm_master

//--- qsfm_pkg.sv
// Constants and types shared by the quad serial flash master.
package qsfm_pkg;
   // -------------------------------------------------------------------
   // Clock and timing
   // -------------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int SCK_MAX_MHZ = 32;
   localparam int SCK_MIN_MHZ = 2;
   // Fastest half period rounds up, slowest rounds down, in ref cycles.
   localparam int HALF_MIN = (CLK_MHZ + 2 * SCK_MAX_MHZ - 1) / (2 * SCK_MAX_MHZ);
   localparam int HALF_MAX = CLK_MHZ / (2 * SCK_MIN_MHZ);
   localparam int CS_HIGH_NS = 30;
   localparam int CS_HIGH_CYC = (CS_HIGH_NS * CLK_MHZ + 999) / 1000;
   localparam int DUMMY_CYC_DEF = 8;

   // -------------------------------------------------------------------
   // Frame layout
   // -------------------------------------------------------------------
   localparam int OPC_BITS = 8;
   localparam int ADDR_BITS = 32;
   localparam int XIP_OFS_BITS = 27;
   localparam int CUST_MAX_BYTES = 8;

   // -------------------------------------------------------------------
   // Built-in opcodes (plain defaults, chosen to match the attached part)
   // -------------------------------------------------------------------
   localparam logic [7:0] OPC_READ1 = 8'h13;
   localparam logic [7:0] OPC_READ2 = 8'h3C;
   localparam logic [7:0] OPC_READ4 = 8'h6C;
   localparam logic [7:0] OPC_PROG1 = 8'h12;
   localparam logic [7:0] OPC_PROG2 = 8'hA2;
   localparam logic [7:0] OPC_PROG4 = 8'h34;
   localparam logic [7:0] OPC_DPD_IN = 8'hB9;
   localparam logic [7:0] OPC_DPD_OUT = 8'hAB;

   // -------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------
   typedef enum logic [1:0] {
      LANE_1 = 2'b00,
      LANE_2 = 2'b01,
      LANE_4 = 2'b10
   } qsfm_lane_t;

   typedef enum logic [2:0] {
      CMD_READ = 3'b000,
      CMD_WRITE = 3'b001,
      CMD_CUSTOM = 3'b010,
      CMD_DPD_ENTER = 3'b011,
      CMD_DPD_EXIT = 3'b100
   } qsfm_cmd_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_OPC = 4'b0001,
      ST_ADDR = 4'b0010,
      ST_DUMMY = 4'b0011,
      ST_TX = 4'b0100,
      ST_FETCH = 4'b0101,
      ST_RX = 4'b0110,
      ST_STORE = 4'b0111,
      ST_CTX = 4'b1000,
      ST_CRX = 4'b1001,
      ST_GAP = 4'b1010
   } qsfm_state_t;
endpackage

//--- qsfm_sck_gen.sv
// Serial clock divider producing the flash clock and its edge strobes.
`timescale 1ns/1ps
module qsfm_sck_gen #(
   parameter int HW = 5
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_run,
   input wire logic [HW-1:0] i_half,
   output logic o_sck,
   output logic o_rise,
   output logic o_fall
);
   // -------------------------------------------------------------------
   // Half period clamp and edge strobes
   // -------------------------------------------------------------------
   logic [HW-1:0] cnt;
   logic [HW-1:0] half;
   logic tick;

   // Out-of-range settings are pinned to the legal band, never beyond.
   assign half = (i_half < HW'(qsfm_pkg::HALF_MIN)) ? HW'(qsfm_pkg::HALF_MIN) :
                 (i_half > HW'(qsfm_pkg::HALF_MAX)) ? HW'(qsfm_pkg::HALF_MAX) :
                 i_half; // [RL2]
   assign tick = i_run && (cnt == half - 1'b1);
   assign o_rise = tick && !o_sck;
   assign o_fall = tick && o_sck;

   // The clock idles low so every frame starts in mode 0.
   always_ff @(posedge i_ref_clk) begin
      if (i_rst || !i_run) begin
         cnt <= '0;
         o_sck <= 1'b0;
      end else if (tick) begin
         cnt <= '0;
         o_sck <= ~o_sck;
      end else begin
         cnt <= cnt + 1'b1;
      end
   end

   // -------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------
   a_sck_half_min: assert property (@(posedge i_ref_clk) disable iff (i_rst)
      ($changed(o_sck) && i_run) |=> $stable(o_sck)) // [RL2]
      else $error("serial clock half period below minimum");
endmodule // qsfm_sck_gen

//--- qsfm_flash_model.sv
// Behavioural serial flash that answers reads on one, two or four lines.
`timescale 1ns/1ps
module qsfm_flash_model #(
   parameter int DUMMY = 8,
   parameter logic [7:0] RSP_OPC = 8'h9F
) (
   input wire logic i_sck,
   input wire logic i_cs_n,
   input wire logic i_mosi,
   output logic [3:0] o_io = 4'h5
);
   logic [7:0] opc;
   logic [7:0] b;
   int n = 0;
   int k, ln, st;

   // Count clock cycles and collect the opcode while selected.
   always @(posedge i_sck or posedge i_cs_n) begin
      if (i_cs_n) begin
         n <= 0;
      end else begin
         if (n < 8) opc <= {opc[6:0], i_mosi};
         n <= n + 1;
      end
   end

   // Shift out on the falling edge; bytes count up from 8'h10.
   always @(negedge i_sck or posedge i_cs_n) begin
      ln = (opc == qsfm_pkg::OPC_READ4) ? 4 :
           (opc == qsfm_pkg::OPC_READ2) ? 2 : 1;
      st = (opc == RSP_OPC) ? 8 :
           (ln > 1 || opc == qsfm_pkg::OPC_READ1) ? 40 + DUMMY : 99999;
      o_io <= ~o_io; // Released lines never keep a level.
      if (!i_cs_n && n >= 8 && n >= st) begin
         k = (n - st) * ln;
         b = (8'h10 + 8'(k / 8)) << (k % 8);
         if (ln == 4) o_io <= b[7:4];
         else if (ln == 2) o_io[1:0] <= b[7:6];
         else o_io[1] <= b[7];
      end
   end
endmodule // qsfm_flash_model

//--- qsfm_master_bench.sv
// Self-checking bench for the quad serial flash master.
`timescale 1ns/1ps
module qsfm_master_bench;
   logic i_ref_clk = 1'b0, i_rst = 1'b1, i_cmd_valid = 1'b0;
   logic i_xip_valid = 1'b0, i_ram_rd_ack = 1'b0, i_ram_wr_ack = 1'b0;
   logic [4:0] i_half = 5'h04;
   logic [2:0] i_cmd_kind = 3'h0;
   logic [1:0] i_cmd_lanes = 2'h0, i_xip_lanes = 2'h0;
   logic [31:0] i_cmd_addr = 32'hA5C3_0F81, i_cmd_ram_addr = 32'h0;
   logic [31:0] i_xip_base = 32'hF000_0000, i_ram_rdata = 32'h0;
   logic [15:0] i_cmd_words = 16'h0;
   logic [26:0] i_xip_ofs = 27'h7FF_FFFC;
   logic [63:0] i_cust_data = 64'h0;
   logic [7:0] i_cust_opcode = 8'h9F; // Matches the model's reply opcode.
   logic [3:0] i_cust_tx_len = 4'h0, i_cust_rx_len = 4'h2;
   wire [3:0] i_io_in, fl_io;
   logic o_cmd_ready, o_xip_ready, o_xip_rvalid, o_ram_rd_req, o_ram_wr_req;
   logic o_busy, o_done, o_sck, o_cs_n;
   logic [31:0] o_xip_rdata, o_ram_addr, o_ram_wdata, wr_data, wr_addr, rd_addr;
   logic [63:0] o_cust_rsp;
   logic [3:0] o_io_out, o_io_oe, last_oe;
   logic [39:0] sh;
   logic [7:0] db;
   int nb, err_count, tests_run, rd_cnt, rv_cnt;
   time t0, per;

   qsfm_master #(.DUMMY_CYC(4)) qsfm_master_i (.*);
   qsfm_flash_model #(.DUMMY(4)) qsfm_flash_model_i (.i_sck(o_sck),
      .i_cs_n(o_cs_n), .i_mosi(o_io_out[0]), .o_io(fl_io));

   // Each line shows whoever drives it.
   assign i_io_in = (o_io_oe & o_io_out) | (~o_io_oe & fl_io);
   always #5 i_ref_clk = ~i_ref_clk;

   // RAM side answers each request one cycle late.
   always @(posedge i_ref_clk) begin
      i_ram_rd_ack <= o_ram_rd_req & ~i_ram_rd_ack;
      i_ram_wr_ack <= o_ram_wr_req & ~i_ram_wr_ack;
      i_ram_rdata <= {24'hC0DE5A, o_ram_addr[7:0]};
      if (o_ram_rd_req && i_ram_rd_ack) begin
         rd_cnt++;
         rd_addr <= o_ram_addr;
      end
      if (o_ram_wr_req && i_ram_wr_ack) {wr_data, wr_addr} <= {o_ram_wdata, o_ram_addr};
      if (o_xip_rvalid === 1'b1) rv_cnt++;
   end

   // Wire monitor: line 0 bits, clock period and enables per frame.
   always @(negedge o_cs_n) nb = 0;
   always @(posedge o_sck) if (!o_cs_n) begin
      if (nb < 40) sh = {sh[38:0], o_io_out[0]};
      else if (nb < 48) db = {db[6:0], o_io_out[0]};
      nb++;
      per = $time - t0;
      t0 = $time;
      last_oe = o_io_oe;
   end

   task automatic wrap_up();
      $display("errors %0d checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic chk(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("MISMATCH %0t %s", $time, msg);
      end
   endtask

   // Wait for the done pulse, sampled away from the driving edge.
   task automatic wait_done();
      int k;
      for (k = 0; k < 20000 && o_done !== 1'b1; k++) @(negedge i_ref_clk);
      if (k == 20000) begin
         chk(1'b0, "no done");
         wrap_up();
      end
   endtask

   task automatic cmd(input logic [2:0] k, input logic [1:0] l,
                      input logic [15:0] w, input logic [31:0] r);
      @(posedge i_ref_clk);
      {i_cmd_kind, i_cmd_lanes, i_cmd_words, i_cmd_ram_addr} <= {k, l, w, r};
      i_cmd_valid <= 1'b1;
      @(posedge i_ref_clk);
      i_cmd_valid <= 1'b0;
      wait_done();
   endtask

   task automatic t_dpd();
      cmd(qsfm_pkg::CMD_DPD_ENTER, 2'h0, 16'h0, 32'h0);
      chk(nb == 8 && sh[7:0] === qsfm_pkg::OPC_DPD_IN, "enter");
      cmd(qsfm_pkg::CMD_DPD_EXIT, 2'h0, 16'h0, 32'h0);
      chk(nb == 8 && sh[7:0] === qsfm_pkg::OPC_DPD_OUT, "exit");
   endtask

   // Fetch on each lane count at fast, slow and middle clock rates.
   task automatic t_xip(input logic [1:0] l, input logic [4:0] h);
      logic [7:0] op;
      logic [3:0] rel;
      op = (l == 0) ? qsfm_pkg::OPC_READ1 :
           (l == 1) ? qsfm_pkg::OPC_READ2 : qsfm_pkg::OPC_READ4;
      rel = (l == 0) ? 4'h2 : (l == 1) ? 4'h3 : 4'hF;
      rv_cnt = 0;
      @(posedge i_ref_clk);
      {i_xip_lanes, i_half, i_xip_valid} <= {l, h, 1'b1};
      @(posedge i_ref_clk);
      i_xip_valid <= 1'b0;
      wait_done();
      chk(sh === {op, 32'hF7FF_FFFC}, "fetch frame");
      chk(rv_cnt == 1 && o_xip_rdata === 32'h1312_1110, "fetch data");
      chk((last_oe & rel) === 4'h0, "lines not released");
      chk(per == 20 * h, "clock period");
   endtask

   task automatic t_dma();
      rd_cnt = 0;
      cmd(qsfm_pkg::CMD_WRITE, 2'h0, 16'h2, 32'h124);
      chk(sh === {qsfm_pkg::OPC_PROG1, i_cmd_addr}, "write head");
      chk(nb == 104 && db === 8'h24, "write data");
      chk(rd_cnt == 2 && rd_addr === 32'h128, "ram reads");
      cmd(qsfm_pkg::CMD_READ, 2'h2, 16'h1, 32'h200);
      chk(wr_data === 32'h1312_1110 && wr_addr === 32'h200, "ram write");
   endtask

   task automatic t_cust();
      cmd(qsfm_pkg::CMD_CUSTOM, 2'h0, 16'h0, 32'h0);
      chk(nb == 24 && sh[23:16] === 8'h9F, "custom opcode");
      chk(o_cust_rsp === 64'h1110, "custom reply");
   endtask

   initial begin
      repeat (4) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      @(negedge i_ref_clk);
      chk(o_cs_n === 1'b1 && o_sck === 1'b0 && o_io_oe === 4'h0, "idle");
      chk(o_busy === 1'b0 && o_cmd_ready === 1'b1, "ready");
      chk(o_xip_ready === 1'b1, "fetch ready");
      t_dpd();
      t_xip(2'h0, 5'h02);
      t_xip(2'h1, 5'h19);
      t_xip(2'h2, 5'h04);
      t_dma();
      t_cust();
      wrap_up();
   end
endmodule // qsfm_master_bench
